/* File: hw/crg_seq_pkg.sv */
// Package: register map, field positions, timing counts and types of the reset sequencer
package crg_seq_pkg;

  // ==========================================================
  // Register byte addresses (APB, one aligned word each)
  localparam logic [7:0] ADDR_FACTORY_TEST_REG_ONE = 8'hEC; // index 0x3B times four
  localparam logic [7:0] ADDR_CLOCK_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_ONE = 8'h04;
  localparam logic [7:0] ADDR_LOOP_MULTIPLIER = 8'h08;
  localparam logic [7:0] ADDR_REF_TRIM_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_REF_TRIM_LOW = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_SEQ_STATUS = 8'h1C;
  localparam logic [7:0] FACTORY_TEST_INDEX = 8'h3B;

  // ==========================================================
  // Field positions
  localparam int OSC_ENABLE_BIT = 0;     // clock_control_zero
  localparam int LOCK_IRQ_ENABLE_BIT = 0; // clock_control_one
  localparam int LOCK_CHANGE_BIT = 0;    // irq status and mask
  localparam int RESET_EVENT_BIT = 1;    // irq status and mask
  localparam int IRQ_BITS = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] FACTORY_TEST_RESET = 8'h00;
  localparam logic [7:0] MULT_RESET = 8'h00;
  localparam logic [8:0] TRIM_RESET = 9'h100;

  // ==========================================================
  // Timing, in controlled oscillator cycles
  localparam int CLK_MHZ = 200;
  localparam int PIN_LOW_CYCLES = 516;
  localparam int SAMPLE_WAIT_CYCLES = 256;
  localparam int SEQ_TOTAL_CYCLES = PIN_LOW_CYCLES + SAMPLE_WAIT_CYCLES;
  localparam int SEQ_CNT_W = 10;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    VEC_POR_EXT_ILLEGAL,
    VEC_OSC_FAIL,
    VEC_WATCHDOG
  } vector_type;

  typedef enum {
    SEQ_DRIVE,
    SEQ_WAIT,
    SEQ_HOLD,
    SEQ_RUN
  } seq_state_type;

  typedef struct packed {
    logic power_on;
    logic illegal_addr;
    logic watchdog_timeout;
    logic osc_lost;
    logic osc_below_fail_freq;
  } reset_src_type;

  typedef struct packed {
    logic lock_status;
    logic stop_mode;
  } lock_in_type;

endpackage

/* File: hw/clock_reset_sequencer_lock_irq.sv */
// Reset sequencer with vector choice, lock change flag and APB register file
// Contract
// - Pin low, power-on, illegal access, watchdog or monitor failure starts the sequence.
// - Monitor failure counts only while oscillator enable is set.
// - Drive reset pin low 516 cycles after any event (517 with sync).
// - Enter reset asynchronously; leave it only on running clock edges.
// - After pin release wait 256 cycles, then sample the pin.
// - Low pin: external vector; monitor fail; watchdog; else power-on vector.
// - Core reset held for the whole 772 cycle sequence.
// - Core reset stays held while pin is held low externally.
// - Clock loss or frequency under fail threshold makes a monitor reset.
// - Watchdog timeout starts a reset.
// - Power-on detector indication asserts a power-on reset.
// - Lock change flag sets on every lock status change, except while stop mode or a config write clears lock.
// - Lock interrupt only when enable and flag set; maskable by processor.
// - Writing one clears the lock change flag; zero is ignored.
// - Factory test register readable any time, writes ignored.
// - During startup core clock is oscillator clock, bus clock half of it.
// - External oscillator off when enable is zero, full swing when one.
// - Stop entry or control zero, multiplier, trim write while locked clears lock silently.
`timescale 1ns/100ps

module clock_reset_sequencer_lock_irq #(
  parameter int PIN_LOW = crg_seq_pkg::PIN_LOW_CYCLES,
  parameter int SAMPLE_WAIT = crg_seq_pkg::SAMPLE_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset sources and lock inputs
  input wire crg_seq_pkg::reset_src_type reset_src,
  input wire crg_seq_pkg::lock_in_type lock_in,
  // Reset pin, open drain
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  // Core side
  output logic core_reset,
  output crg_seq_pkg::vector_type vector_sel,
  output logic vector_valid,
  output logic bus_clk,
  output logic osc_run,
  output logic lock_status,
  output logic lock_irq_req,
  output logic irq
);
  import crg_seq_pkg::*;

  // ==========================================================
  // Synchronisers
  logic pin_meta_r, pin_sync_r;
  logic [4:0] src_meta_r, src_sync_r;
  logic lock_meta_r, lock_sync_r, stop_meta_r, stop_sync_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      src_meta_r <= 5'h00;
      src_sync_r <= 5'h00;
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
      stop_meta_r <= 1'b0;
      stop_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= reset_pin_in;
      pin_sync_r <= pin_meta_r;
      src_meta_r <= reset_src;
      src_sync_r <= src_meta_r;
      lock_meta_r <= lock_in.lock_status;
      lock_sync_r <= lock_meta_r;
      stop_meta_r <= lock_in.stop_mode;
      stop_sync_r <= stop_meta_r;
    end
  end

  reset_src_type src;
  assign src = reset_src_type'(src_sync_r);

  // ==========================================================
  // Registers
  logic osc_enable_r, lock_irq_enable_r;
  logic [7:0] mult_r;
  logic [8:0] trim_r;
  logic [IRQ_BITS-1:0] irq_status_r, irq_mask_r;
  logic lock_status_r, lock_prev_r;
  logic wr_en, rd_en;
  logic cfg_write;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign cfg_write = wr_en && (paddr == ADDR_CLOCK_CONTROL_ZERO || paddr == ADDR_LOOP_MULTIPLIER
    || paddr == ADDR_REF_TRIM_HIGH || paddr == ADDR_REF_TRIM_LOW);

  // ==========================================================
  // Reset event detection
  logic osc_fail, any_event;
  assign osc_fail = osc_enable_r && (src.osc_lost || src.osc_below_fail_freq);
  assign any_event = !pin_sync_r || src.power_on || src.illegal_addr
    || src.watchdog_timeout || osc_fail;

  // ==========================================================
  // Sequence
  seq_state_type state_r;
  logic [SEQ_CNT_W-1:0] cnt_r;
  logic osc_pend_r, wdog_pend_r;
  logic seq_start;

  // Restart only from run; a pin held low by us must not retrigger
  assign seq_start = (state_r == SEQ_RUN) && any_event;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SEQ_DRIVE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        SEQ_DRIVE: begin
          if (cnt_r == SEQ_CNT_W'(PIN_LOW - 1)) begin
            state_r <= SEQ_WAIT;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        SEQ_WAIT: begin
          if (cnt_r == SEQ_CNT_W'(SAMPLE_WAIT - 1)) begin
            state_r <= pin_sync_r ? SEQ_RUN : SEQ_HOLD;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        SEQ_HOLD: begin
          if (pin_sync_r) begin
            state_r <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (seq_start) begin
            state_r <= SEQ_DRIVE;
            cnt_r <= '0;
          end
        end
        default: state_r <= SEQ_DRIVE;
      endcase
    end
  end

  logic sample_now;
  assign sample_now = (state_r == SEQ_WAIT) && (cnt_r == SEQ_CNT_W'(SAMPLE_WAIT - 1));

  // Pending causes, held until the vector is chosen
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_pend_r <= 1'b0;
      wdog_pend_r <= 1'b0;
    end else if (sample_now) begin
      osc_pend_r <= 1'b0;
      wdog_pend_r <= 1'b0;
    end else if (state_r != SEQ_HOLD) begin
      if (osc_fail) osc_pend_r <= 1'b1;
      if (src.watchdog_timeout) wdog_pend_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vector_sel <= VEC_POR_EXT_ILLEGAL;
      vector_valid <= 1'b0;
    end else begin
      if (seq_start) vector_valid <= 1'b0;
      if (sample_now) begin
        vector_valid <= 1'b1;
        if (!pin_sync_r) vector_sel <= VEC_POR_EXT_ILLEGAL;
        else if (osc_pend_r) vector_sel <= VEC_OSC_FAIL;
        else if (wdog_pend_r) vector_sel <= VEC_WATCHDOG;
        else vector_sel <= VEC_POR_EXT_ILLEGAL;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= !(seq_start || (state_r == SEQ_DRIVE
        && cnt_r != SEQ_CNT_W'(PIN_LOW - 1)));
      core_reset <= !(state_r == SEQ_RUN && !seq_start)
        && !((state_r == SEQ_HOLD) && pin_sync_r)
        && !(sample_now && pin_sync_r);
    end
  end

  // ==========================================================
  // Bus clock: oscillator clock divided by two
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) bus_clk <= 1'b0;
    else bus_clk <= !bus_clk;
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_enable_r <= 1'b0;
      lock_irq_enable_r <= 1'b0;
      mult_r <= MULT_RESET;
      trim_r <= TRIM_RESET;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      if (paddr == ADDR_CLOCK_CONTROL_ZERO) osc_enable_r <= pwdata[OSC_ENABLE_BIT];
      else if (paddr == ADDR_CLOCK_CONTROL_ONE) lock_irq_enable_r <= pwdata[LOCK_IRQ_ENABLE_BIT];
      else if (paddr == ADDR_LOOP_MULTIPLIER) mult_r <= pwdata[7:0];
      else if (paddr == ADDR_REF_TRIM_HIGH) trim_r[8] <= pwdata[0];
      else if (paddr == ADDR_REF_TRIM_LOW) trim_r[7:0] <= pwdata[7:0];
      else if (paddr == ADDR_IRQ_MASK) irq_mask_r <= pwdata[IRQ_BITS-1:0];
    end
  end

  assign osc_run = osc_enable_r;

  // ==========================================================
  // Lock status and change flag
  logic silent_clear;
  assign silent_clear = stop_sync_r || cfg_write;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_status_r <= 1'b0;
      lock_prev_r <= 1'b0;
    end else begin
      lock_prev_r <= lock_sync_r;
      if (silent_clear) lock_status_r <= 1'b0;
      else if (lock_sync_r != lock_prev_r) lock_status_r <= lock_sync_r;
    end
  end

  assign lock_status = lock_status_r;

  logic lock_change;
  assign lock_change = !silent_clear && (lock_sync_r != lock_prev_r);

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status_r <= '0;
    end else begin
      if (wr_en && paddr == ADDR_IRQ_STATUS) begin
        irq_status_r <= irq_status_r & ~pwdata[IRQ_BITS-1:0];
      end
      if (lock_change) irq_status_r[LOCK_CHANGE_BIT] <= 1'b1;
      if (sample_now) irq_status_r[RESET_EVENT_BIT] <= 1'b1;
    end
  end

  assign lock_irq_req = lock_irq_enable_r && irq_status_r[LOCK_CHANGE_BIT];
  assign irq = |(irq_status_r & irq_mask_r);

  // ==========================================================
  // Read path
  logic [31:0] rd_nxt;
  logic addr_ok;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == ADDR_FACTORY_TEST_REG_ONE) rd_nxt[7:0] = FACTORY_TEST_RESET;
    else if (paddr == ADDR_CLOCK_CONTROL_ZERO) rd_nxt[OSC_ENABLE_BIT] = osc_enable_r;
    else if (paddr == ADDR_CLOCK_CONTROL_ONE) rd_nxt[LOCK_IRQ_ENABLE_BIT] = lock_irq_enable_r;
    else if (paddr == ADDR_LOOP_MULTIPLIER) rd_nxt[7:0] = mult_r;
    else if (paddr == ADDR_REF_TRIM_HIGH) rd_nxt[0] = trim_r[8];
    else if (paddr == ADDR_REF_TRIM_LOW) rd_nxt[7:0] = trim_r[7:0];
    else if (paddr == ADDR_IRQ_STATUS) rd_nxt[IRQ_BITS-1:0] = irq_status_r;
    else if (paddr == ADDR_IRQ_MASK) rd_nxt[IRQ_BITS-1:0] = irq_mask_r;
    else if (paddr == ADDR_SEQ_STATUS) rd_nxt[3:0] = {lock_status_r, vector_valid, vector_sel};
    else addr_ok = 1'b0;
  end

  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= rd_nxt;
    else if (rd_en) prdata <= prdata;
  end

endmodule

/* File: verification/crg_seq_monitor.sv */
// Checker of reset sequence timing and clock outputs at the sequencer ports
`timescale 1ns/100ps
module crg_seq_monitor #(
  parameter int PIN_LOW = 516,
  parameter int SAMPLE_WAIT = 256
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Watched ports
  input wire crg_seq_pkg::reset_src_type reset_src,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic core_reset,
  input wire logic vector_valid,
  input wire logic bus_clk
);
  import crg_seq_pkg::*;
  int low_cnt;
  int high_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================
  // Cycles in drive phase and after release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 0;
      high_cnt <= 0;
    end else begin
      low_cnt <= reset_pin_oe_n ? 0 : low_cnt + 1;
      high_cnt <= !reset_pin_oe_n ? 0 : (high_cnt < 4000 ? high_cnt + 1 : high_cnt);
    end
  end
  // ==========================================
  // Assertions
  a_drive_length: assert property ($rose(reset_pin_oe_n) |-> low_cnt >= PIN_LOW - 1 && low_cnt <= PIN_LOW + 2)
    else $error("reset pin drive length wrong");
  a_pin_low_only: assert property (reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_core_in_drive: assert property (!reset_pin_oe_n |-> core_reset)
    else $error("core reset low while pin driven");
  a_core_after_wait: assert property ($fell(core_reset) |-> reset_pin_oe_n && high_cnt >= SAMPLE_WAIT - 1)
    else $error("core reset released early");
  a_vec_after_wait: assert property ($rose(vector_valid) |-> high_cnt >= SAMPLE_WAIT - 1)
    else $error("vector chosen before wait");
  a_core_pin_high: assert property ($fell(core_reset) |-> $past(reset_pin_in, 2))
    else $error("core reset released while pin low");
  a_vec_clear_event: assert property ($fell(reset_pin_oe_n) |-> !vector_valid)
    else $error("vector valid kept on new event");
  a_bus_clk_half: assert property ($past(resetn) |-> bus_clk != $past(bus_clk))
    else $error("bus clock not half rate");
  a_wdog_start: assert property ($rose(reset_src.watchdog_timeout) && !core_reset |-> ##[1:6] !reset_pin_oe_n)
    else $error("watchdog did not start sequence");
endmodule

bind clock_reset_sequencer_lock_irq crg_seq_monitor #(.PIN_LOW(PIN_LOW), .SAMPLE_WAIT(SAMPLE_WAIT)) u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .reset_src(reset_src), .reset_pin_in(reset_pin_in),
  .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .core_reset(core_reset),
  .vector_valid(vector_valid), .bus_clk(bus_clk));

/* File: verification/reset_pin_model.sv */
// Board side of the reset pin: pull-up and an external reset button
`timescale 1ns/100ps
module reset_pin_model (
  // Device side
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Board side
  input wire logic button_low,
  output logic pin
);
  // Pull-up wins unless device or button pulls low
  assign pin = ((!pin_oe_n && !pin_out) || button_low) ? 1'b0 : 1'b1;
endmodule

/* File: verification/clock_reset_sequencer_lock_irq_tb_top.sv */
// Self-checking bench of the reset sequencer and lock interrupt
`timescale 1ns/100ps
module clock_reset_sequencer_lock_irq_tb_top;
  import crg_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  reset_src_type reset_src = '0;
  lock_in_type lock_in = '0;
  logic button_low = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr, pin, pin_out, oe_n, core_reset, valid;
  logic bus_clk, osc_run, lock_status, lock_irq_req, irq;
  vector_type vector_sel;
  logic [4:0] tbl [7] = '{5'h10, 5'h08, 5'h04, 5'h06, 5'h02, 5'h01, 5'h04};
  int err_total = 0;
  int num_checks = 0;
  int n;
  always #2.5 sys_clk = ~sys_clk;
  clock_reset_sequencer_lock_irq u_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_src(reset_src), .lock_in(lock_in),
    .reset_pin_in(pin), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
    .core_reset(core_reset), .vector_sel(vector_sel), .vector_valid(valid), .bus_clk(bus_clk),
    .osc_run(osc_run), .lock_status(lock_status), .lock_irq_req(lock_irq_req), .irq(irq));
  reset_pin_model u_pin (.pin_out(pin_out), .pin_oe_n(oe_n), .button_low(button_low),
    .pin(pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic hang(input int cnt);
    if (cnt >= 3000) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    hang(n);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask
  // Reference model of the vector choice
  function automatic int exp_vec(input logic [4:0] s, input int hold);
    if (hold > 0) return 0;
    if (s[1:0] != 2'b00) return 1;
    return s[2] ? 2 : 0;
  endfunction
  task automatic finish_seq(input int v);
    n = 0;
    while (core_reset !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    hang(n);
    @(negedge sys_clk);
    check(valid, 1'b1);
    check(vector_sel, v);
  endtask
  task automatic run_seq(input logic [4:0] s, input int hold);
    @(posedge sys_clk);
    reset_src <= s;
    button_low <= hold > 0;
    repeat (5) @(posedge sys_clk);
    reset_src <= '0;
    @(negedge sys_clk);
    check(oe_n, 1'b0);
    repeat (hold) @(posedge sys_clk);
    if (hold > 0) check(core_reset, 1'b1);
    button_low <= 1'b0;
    finish_seq(exp_vec(s, hold));
  endtask
  initial begin
    void'($urandom(32'h00DF));
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      resetn <= 1'b0;
      #1;
      check({oe_n, core_reset}, 2'b01);
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      finish_seq(0);
    end
    apb(1'b1, ADDR_FACTORY_TEST_REG_ONE, $urandom);
    apb(1'b0, ADDR_FACTORY_TEST_REG_ONE, 32'h0);
    check(rd, {24'h0, FACTORY_TEST_RESET});
    apb(1'b1, 8'hF4, $urandom);
    check(perr, 1'b1);
    apb(1'b0, 8'hF4, 32'h0);
    check(rd, 32'h0);
    @(posedge sys_clk);
    reset_src <= 5'h03;
    repeat (20) @(posedge sys_clk);
    reset_src <= '0;
    @(negedge sys_clk);
    check(oe_n, 1'b1);
    apb(1'b1, ADDR_CLOCK_CONTROL_ZERO, 32'h1);
    check(osc_run, 1'b1);
    foreach (tbl[i]) run_seq(tbl[i], 0);
    run_seq(5'h06, 800 + $urandom % 200);
    for (int i = 0; i < 2; i++) begin
      lock_in.lock_status <= (i == 0);
      repeat (6) @(posedge sys_clk);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check(rd[LOCK_CHANGE_BIT], 1'b1);
      check({lock_irq_req, irq}, {i[0], i[0]});
      apb(1'b1, ADDR_CLOCK_CONTROL_ONE, 32'h1);
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0);
      check({lock_irq_req, irq}, 2'b11);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      check({lock_irq_req, irq}, 2'b00);
    end
    // Silent lock clear by a config write, then by stop entry
    for (int j = 0; j < 2; j++) begin
      lock_in.lock_status <= 1'b0;
      repeat (6) @(posedge sys_clk);
      lock_in.lock_status <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check(lock_status, 1'b1);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      if (j == 0) begin
        apb(1'b1, ADDR_LOOP_MULTIPLIER, $urandom);
      end else begin
        lock_in.stop_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
      end
      check(lock_status, 1'b0);
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
      check(rd[LOCK_CHANGE_BIT], 1'b0);
    end
    lock_in.stop_mode <= 1'b0;
    end_of_test();
  end
endmodule
